// file: shared/mdl_pkg.sv
// Constants and register map of the motor duty limiter PWM block
// Functional notes
// - Duty is signed, -600 reverse to 600 forward
// - Forward drives A to supply, B to ground
// - Inversion swaps terminals for both signs
// - PWM runs at 20 kHz or 5 kHz
// - Asymmetric keeps separate forward and reverse limits
// - Duty magnitude clamped to direction maximum
// - Growth per period limited by acceleration limit
// - Scaled current kept at or below maximum
// - Hold zero for brake time before reversing
// - Reduced maximum while feedback is out of range
// - Motor off brakes or coasts by setting
// - Drive-brake style: zero duty means braking
// - Drive-coast style alternates drive and coast
// - Drive-coast zero duty follows motor-off setting
// - Disabled errors still recorded as occurred
// - Enabled errors stop motor while present
// - Latched errors stop until new target
package mdl_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 200_000_000;
	localparam int PWM_FAST_HZ = 20_000;
	localparam int PWM_SLOW_HZ = 5_000;
	localparam logic [15:0] PER_FAST = 16'(CLK_HZ / PWM_FAST_HZ);
	localparam logic [15:0] PER_SLOW = 16'(CLK_HZ / PWM_SLOW_HZ);
	localparam int PID_US = 1000;
	localparam int PID_CYC_DEF = CLK_HZ / 1_000_000 * PID_US;
	// ------------------------------------------------------------
	// Duty and error codes
	// ------------------------------------------------------------
	localparam logic [9:0] DUTY_FULL = 10'd600;
	localparam int ERR_N = 4;
	localparam logic [1:0] EM_DIS = 2'h0;
	localparam logic [1:0] EM_LATCH = 2'h2;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_TGT = 8'h04;
	localparam logic [7:0] A_MAXD = 8'h08;
	localparam logic [7:0] A_ACC = 8'h0c;
	localparam logic [7:0] A_MAXC = 8'h10;
	localparam logic [7:0] A_BRK = 8'h14;
	localparam logic [7:0] A_OORD = 8'h18;
	localparam logic [7:0] A_FBL = 8'h1c;
	localparam logic [7:0] A_ECFG = 8'h20;
	localparam logic [7:0] A_CAL = 8'h24;
	localparam logic [7:0] A_OFF = 8'h28;
	localparam logic [7:0] A_STAT = 8'h2c;
	localparam logic [7:0] A_CLR = 8'h30;
	localparam logic [7:0] A_IEN = 8'h34;
	localparam logic [7:0] A_STATE = 8'h38;
	// ------------------------------------------------------------
	// Control bits and reset values
	// ------------------------------------------------------------
	localparam int C_INV = 0;
	localparam int C_SLOW = 1;
	localparam int C_ASYM = 2;
	localparam int C_OFFBRK = 3;
	localparam int C_COAST = 4;
	localparam logic [4:0] CTRL_RST = 5'h08;
	localparam logic [31:0] MAXD_RST = 32'h0258_0258;
	localparam logic [31:0] MAXC_RST = 32'hffff_ffff;
	localparam logic [31:0] FBL_RST = 32'h0fff_0000;
	localparam logic [7:0] CAL_RST = 8'h01;
endpackage

// file: core/mdl_limiter.sv
// Duty limiter, error handling and H-bridge PWM with APB registers
`timescale 1ns/1ps
module mdl_limiter #(
	parameter int PID_CYC = mdl_pkg::PID_CYC_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [11:0] fb_val,
	input wire logic [7:0] cur_raw,
	input wire logic [3:0] err_in,
	output logic term_a_lvl,
	output logic term_a_oe,
	output logic term_b_lvl,
	output logic term_b_oe,
	output logic irq
);
	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [4:0] ctrl_r;
	logic signed [10:0] tgt_r;
	logic [31:0] maxd_r, acc_r, maxc_r, brk_r, oord_r, fbl_r;
	logic [7:0] ecfg_r, cal_r;
	logic [4:0] st_r, ien_r;
	logic off_r, await_r;
	logic signed [10:0] duty_r;
	logic [7:0] brk_cnt_r;
	logic last_dir_r, last_vld_r;
	logic [31:0] pid_cnt_r;
	logic [15:0] pcnt_r;
	logic wr, setup;
	logic [3:0] latch_hit, stop_hit;
	logic run, oor, over, tick;

	assign wr = psel & penable & pwrite;
	assign setup = psel & ~penable;
	assign pready = penable;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= mdl_pkg::CTRL_RST;
			maxd_r <= mdl_pkg::MAXD_RST;
			acc_r <= '0;
			maxc_r <= mdl_pkg::MAXC_RST;
			brk_r <= '0;
			oord_r <= mdl_pkg::MAXD_RST;
			fbl_r <= mdl_pkg::FBL_RST;
			ecfg_r <= '0;
			cal_r <= mdl_pkg::CAL_RST;
			ien_r <= '0;
			tgt_r <= '0;
		end else if (wr) begin
			case (paddr)
				mdl_pkg::A_CTRL: ctrl_r <= pwdata[4:0];
				mdl_pkg::A_TGT: tgt_r <= pwdata[10:0];
				mdl_pkg::A_MAXD: maxd_r <= pwdata;
				mdl_pkg::A_ACC: acc_r <= pwdata;
				mdl_pkg::A_MAXC: maxc_r <= pwdata;
				mdl_pkg::A_BRK: brk_r <= pwdata;
				mdl_pkg::A_OORD: oord_r <= pwdata;
				mdl_pkg::A_FBL: fbl_r <= pwdata;
				mdl_pkg::A_ECFG: ecfg_r <= pwdata[7:0];
				mdl_pkg::A_CAL: cal_r <= pwdata[7:0];
				mdl_pkg::A_IEN: ien_r <= pwdata[4:0];
				default: ;
			endcase
		end
	end

	// Read data caught in setup so it comes from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pslverr <= 1'b0;
		end else if (setup) begin
			pslverr <= 1'b0;
			case (paddr)
				mdl_pkg::A_CTRL: prdata <= {27'h0, ctrl_r};
				mdl_pkg::A_TGT: prdata <= 32'(tgt_r);
				mdl_pkg::A_MAXD: prdata <= maxd_r;
				mdl_pkg::A_ACC: prdata <= acc_r;
				mdl_pkg::A_MAXC: prdata <= maxc_r;
				mdl_pkg::A_BRK: prdata <= brk_r;
				mdl_pkg::A_OORD: prdata <= oord_r;
				mdl_pkg::A_FBL: prdata <= fbl_r;
				mdl_pkg::A_ECFG: prdata <= {24'h0, ecfg_r};
				mdl_pkg::A_CAL: prdata <= {24'h0, cal_r};
				mdl_pkg::A_STAT: prdata <= {27'h0, st_r};
				mdl_pkg::A_IEN: prdata <= {27'h0, ien_r};
				mdl_pkg::A_STATE: prdata <= {12'h0, over, oor,
					await_r, run, 5'h0, duty_r};
				mdl_pkg::A_OFF, mdl_pkg::A_CLR: prdata <= '0;
				default: begin
					prdata <= '0;
					pslverr <= 1'b1;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Errors, off command and interrupt
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < mdl_pkg::ERR_N; gi++) begin : g_err
			assign stop_hit[gi] = err_in[gi]
				& (ecfg_r[2*gi+:2] != mdl_pkg::EM_DIS);
			assign latch_hit[gi] = err_in[gi]
				& (ecfg_r[2*gi+:2] == mdl_pkg::EM_LATCH);
		end
	endgenerate

	logic tgt_wr;
	assign tgt_wr = wr & (paddr == mdl_pkg::A_TGT);

	// Set beats clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= (st_r & ~((wr && paddr == mdl_pkg::A_CLR)
				? pwdata[4:0] : 5'h0))
				| {|latch_hit, err_in};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			await_r <= 1'b0;
			off_r <= 1'b0;
		end else begin
			if (|latch_hit)
				await_r <= 1'b1;
			else if (tgt_wr)
				await_r <= 1'b0;
			if (wr && paddr == mdl_pkg::A_OFF)
				off_r <= 1'b1;
			else if (tgt_wr)
				off_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(st_r & ien_r);
	end

	assign run = ~(|stop_hit) & ~off_r & ~await_r;

	// ------------------------------------------------------------
	// Limit calculation
	// ------------------------------------------------------------
	function automatic logic [9:0] umin(logic [9:0] a, logic [9:0] b);
		return (a < b) ? a : b;
	endfunction

	logic asym;
	logic [9:0] mdf, mdr, acf, acr, cap, mag;
	logic [15:0] cma, mcl;
	logic signed [11:0] up, lo, c1, c2;
	logic [7:0] bdur;
	logic rdir, rev;

	assign asym = ctrl_r[mdl_pkg::C_ASYM];
	assign oor = (fb_val < fbl_r[11:0]) | (fb_val > fbl_r[27:16]);
	assign mag = duty_r[10] ? 10'(-duty_r) : duty_r[9:0];
	assign cma = 16'(cur_raw * cal_r);
	assign mcl = (duty_r < 0 && asym) ? maxc_r[31:16] : maxc_r[15:0];
	assign over = cma > mcl;
	// Back off by an eighth plus one per period while over
	assign cap = (mag == 10'd0) ? 10'd0 : 10'(mag - 1 - (mag >> 3));

	always_comb begin
		acf = acc_r[9:0];
		acr = asym ? acc_r[25:16] : acc_r[9:0];
		mdf = umin(maxd_r[9:0], mdl_pkg::DUTY_FULL);
		mdr = umin(asym ? maxd_r[25:16] : maxd_r[9:0],
			mdl_pkg::DUTY_FULL);
		if (oor) begin
			mdf = umin(mdf, oord_r[9:0]);
			mdr = umin(mdr, asym ? oord_r[25:16] : oord_r[9:0]);
		end
		if (over) begin
			mdf = umin(mdf, cap);
			mdr = umin(mdr, cap);
		end
		// Zero acceleration limit means unlimited
		up = (acf == 10'd0) ? 12'sd600
			: (duty_r > 0 ? 12'(duty_r) : 12'sd0) + $signed({2'b0, acf});
		lo = (acr == 10'd0) ? -12'sd600
			: (duty_r < 0 ? 12'(duty_r) : 12'sd0) - $signed({2'b0, acr});
		c1 = 12'(tgt_r);
		if (c1 > up)
			c1 = up;
		if (c1 < lo)
			c1 = lo;
		c2 = c1;
		if (c2 > $signed({2'b0, mdf}))
			c2 = $signed({2'b0, mdf});
		if (c2 < -$signed({2'b0, mdr}))
			c2 = -$signed({2'b0, mdr});
		rdir = c2 > 0;
		rev = (c2 != 0) & last_vld_r & (rdir != last_dir_r);
		bdur = (last_dir_r || !asym) ? brk_r[7:0] : brk_r[23:16];
	end

	// ------------------------------------------------------------
	// PID period and duty update
	// ------------------------------------------------------------
	assign tick = pid_cnt_r == 32'(PID_CYC - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pid_cnt_r <= '0;
		else
			pid_cnt_r <= tick ? 32'h0 : pid_cnt_r + 1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			duty_r <= '0;
			brk_cnt_r <= '0;
			last_dir_r <= 1'b0;
			last_vld_r <= 1'b0;
		end else if (!run) begin
			duty_r <= '0;
			brk_cnt_r <= '0;
		end else if (tick) begin
			if (brk_cnt_r != 8'h0) begin
				duty_r <= '0;
				brk_cnt_r <= brk_cnt_r - 8'h1;
				if (brk_cnt_r == 8'h1)
					last_vld_r <= 1'b0;
			end else if (rev && bdur != 8'h0) begin
				duty_r <= '0;
				brk_cnt_r <= bdur;
			end else begin
				duty_r <= 11'(c2);
				if (c2 != 0) begin
					last_dir_r <= rdir;
					last_vld_r <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// PWM output stage
	// ------------------------------------------------------------
	logic [15:0] per;
	logic pwm_on, pos;
	assign per = ctrl_r[mdl_pkg::C_SLOW] ? mdl_pkg::PER_SLOW
		: mdl_pkg::PER_FAST;
	// Cross-multiplied compare avoids a divider
	assign pwm_on = (26'(pcnt_r) * 26'(mdl_pkg::DUTY_FULL))
		< (26'(mag) * 26'(per));
	assign pos = (duty_r > 0) ^ ctrl_r[mdl_pkg::C_INV];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pcnt_r <= '0;
		else if (pcnt_r >= per - 16'h1)
			pcnt_r <= '0;
		else
			pcnt_r <= pcnt_r + 16'h1;
	end

	logic offst_oe;
	assign offst_oe = ctrl_r[mdl_pkg::C_OFFBRK];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			term_a_lvl <= 1'b0;
			term_b_lvl <= 1'b0;
			term_a_oe <= 1'b0;
			term_b_oe <= 1'b0;
		end else begin
			term_a_lvl <= 1'b0;
			term_b_lvl <= 1'b0;
			if (!run || (duty_r == 0 && ctrl_r[mdl_pkg::C_COAST])) begin
				term_a_oe <= offst_oe;
				term_b_oe <= offst_oe;
			end else if (duty_r != 0 && pwm_on) begin
				term_a_lvl <= pos;
				term_b_lvl <= ~pos;
				term_a_oe <= 1'b1;
				term_b_oe <= 1'b1;
			end else begin
				// Brake low, or coast in drive-coast style
				term_a_oe <= ~ctrl_r[mdl_pkg::C_COAST];
				term_b_oe <= ~ctrl_r[mdl_pkg::C_COAST];
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_range;
		duty_r <= 11'sd600 && duty_r >= -11'sd600;
	endproperty
	a_range: assert property (p_range)
		else $error("duty out of range");

	property p_fwd;
		run && duty_r > 0 && pwm_on && !ctrl_r[mdl_pkg::C_INV]
		|=> term_a_lvl && term_a_oe && !term_b_lvl && term_b_oe;
	endproperty
	a_fwd: assert property (p_fwd)
		else $error("forward drive wrong");

	property p_inv;
		run && duty_r > 0 && pwm_on && ctrl_r[mdl_pkg::C_INV]
		|=> !term_a_lvl && term_b_lvl && term_b_oe;
	endproperty
	a_inv: assert property (p_inv)
		else $error("inverted drive wrong");

	// Counter may sit past a shorter period for one cycle after a switch
	property p_per;
		pcnt_r >= per - 16'h1 |=> pcnt_r == 16'h0;
	endproperty
	a_per: assert property (p_per)
		else $error("pwm counter past period");

	property p_max;
		tick && run && brk_cnt_r == 0 && !rev
		|=> duty_r <= $signed({1'b0, $past(mdf)});
	endproperty
	a_max: assert property (p_max)
		else $error("duty above maximum");

	property p_acc;
		tick && run |=> 12'(duty_r) <= $past(up);
	endproperty
	a_acc: assert property (p_acc)
		else $error("acceleration exceeded");

	property p_brk;
		tick && run && brk_cnt_r != 0 |=> duty_r == 0;
	endproperty
	a_brk: assert property (p_brk)
		else $error("duty nonzero during brake");

	property p_off;
		!run && ctrl_r[mdl_pkg::C_OFFBRK]
		|=> term_a_oe && term_b_oe && !term_a_lvl && !term_b_lvl;
	endproperty
	a_off: assert property (p_off)
		else $error("off state not braking");

	property p_occ;
		err_in[0] |=> st_r[0];
	endproperty
	a_occ: assert property (p_occ)
		else $error("occurrence not recorded");

	property p_stop;
		|stop_hit |=> duty_r == 0 ##1 (duty_r == 0 || $past(run));
	endproperty
	a_stop: assert property (p_stop)
		else $error("motor not stopped");

	property p_latch;
		await_r && !tgt_wr |=> await_r && !run;
	endproperty
	a_latch: assert property (p_latch)
		else $error("latched error released");

	c_rev: cover property (tick && rev && bdur != 0);
	c_over: cover property (tick && over && run);
	c_latch: cover property (await_r ##1 !await_r);
endmodule

// file: verif/mdl_bridge.sv
// Behavioural H-bridge and brushed motor model at the bridge terminals
`timescale 1ns/1ps
module mdl_bridge (
	input wire logic term_a_lvl,
	input wire logic term_a_oe,
	input wire logic term_b_lvl,
	input wire logic term_b_oe,
	input wire logic [7:0] load,
	output logic [7:0] cur_raw,
	output logic [1:0] mode
);
	// ----------------------------------------------------------------
	// Bridge state: 0 coast, 1 forward, 2 reverse, 3 brake low
	// ----------------------------------------------------------------
	always_comb begin
		mode = 2'h0;
		if (term_a_oe && term_b_oe) begin
			case ({term_a_lvl, term_b_lvl})
			2'b10: mode = 2'h1;
			2'b01: mode = 2'h2;
			2'b00: mode = 2'h3;
			default: mode = 2'h0;
			endcase
		end
	end
	// ----------------------------------------------------------------
	// Sensed current
	// ----------------------------------------------------------------
	// Winding current keeps flowing while braking, so only coast reads 0
	assign cur_raw = (mode == 2'h0) ? 8'h00 : load;
endmodule

// file: verif/tb.sv
// Self-checking bench for the motor duty limiter PWM block
`timescale 1ns/1ps
module tb;
	localparam int PC = 40;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
	logic [7:0] paddr, cur_raw, load;
	logic [31:0] pwdata, prdata, q;
	logic [11:0] fb_val;
	logic [3:0] err_in;
	logic ta, tao, tb_l, tbo;
	logic [1:0] mode;
	int fail_count, cmp_count, n;
	mdl_limiter #(.PID_CYC(PC)) i_mdl_limiter (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fb_val(fb_val),
		.cur_raw(cur_raw), .err_in(err_in), .term_a_lvl(ta),
		.term_a_oe(tao), .term_b_lvl(tb_l), .term_b_oe(tbo), .irq(irq));
	mdl_bridge i_mdl_bridge (.term_a_lvl(ta), .term_a_oe(tao),
		.term_b_lvl(tb_l), .term_b_oe(tbo), .load(load),
		.cur_raw(cur_raw), .mode(mode));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			fail_count++;
			test_done();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic tk(int t);
		repeat (t * PC) @(posedge pclk);
	endtask
	task automatic duty(string nm, logic [10:0] exp);
		rd(mdl_pkg::A_STATE);
		chk(nm, {21'h0, q[10:0]}, {21'h0, exp});
	endtask
	// Counts cycles in bridge state m after the terminals settle
	task automatic cnt(int len, logic [1:0] m);
		repeat (4) @(posedge pclk);
		n = 0;
		repeat (len) begin
			@(posedge pclk);
			if (mode === m) n++;
		end
	endtask
	// Waits until the read duty differs from old, bounded
	task automatic chg(logic [10:0] old);
		int k;
		k = 0;
		do begin
			rd(mdl_pkg::A_STATE);
			k++;
		end while (q[10:0] === old && k < 60);
		if (k >= 60) begin
			fail_count++;
			test_done();
		end
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		fb_val = 12'h800;
		err_in = 4'h0;
		load = 8'h0;
		fail_count = 0;
		cmp_count = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("idle brake", mode, 2'h3);
		rd(mdl_pkg::A_CTRL);
		chk("ctrl", q, 32'h8);
		rd(mdl_pkg::A_MAXD);
		chk("maxduty", q, mdl_pkg::MAXD_RST);
		rd(8'h3c);
		chk("slverr", e, 1'b1);
		$display("reset and registers done");
		wr(mdl_pkg::A_TGT, 32'h64);
		tk(3);
		duty("duty", 11'h064);
		cnt(10000, 2'h1);
		chk("fwd 20k", n, 1667);
		wr(mdl_pkg::A_CTRL, 32'h9);
		cnt(10000, 2'h2);
		chk("inverted", n, 1667);
		wr(mdl_pkg::A_CTRL, 32'ha);
		cnt(40000, 2'h1);
		chk("fwd 5k", n, 6667);
		wr(mdl_pkg::A_CTRL, 32'h18);
		cnt(10000, 2'h0);
		chk("coast phase", n, 8333);
		wr(mdl_pkg::A_TGT, 32'h0);
		tk(3);
		cnt(100, 2'h3);
		chk("zero brake", n, 100);
		wr(mdl_pkg::A_CTRL, 32'h10);
		cnt(100, 2'h0);
		chk("zero coast", n, 100);
		wr(mdl_pkg::A_CTRL, 32'h0);
		wr(mdl_pkg::A_TGT, 32'h64);
		tk(3);
		wr(mdl_pkg::A_OFF, 32'h0);
		cnt(100, 2'h0);
		chk("off coast", n, 100);
		wr(mdl_pkg::A_CTRL, 32'h8);
		cnt(100, 2'h3);
		chk("off brake", n, 100);
		$display("pwm and motor off done");
		wr(mdl_pkg::A_MAXD, 32'h0258_00c8);
		wr(mdl_pkg::A_TGT, 32'h1f4);
		tk(3);
		duty("max fwd", 11'h0c8);
		wr(mdl_pkg::A_CTRL, 32'hc);
		wr(mdl_pkg::A_MAXD, 32'h012c_00c8);
		wr(mdl_pkg::A_TGT, 32'hffff_fe0c);
		tk(3);
		duty("max rev", 11'h6d4);
		wr(mdl_pkg::A_FBL, 32'h03e8_0000);
		wr(mdl_pkg::A_OORD, 32'h0032_0032);
		tk(3);
		duty("oor", 11'h7ce);
		wr(mdl_pkg::A_FBL, mdl_pkg::FBL_RST);
		wr(mdl_pkg::A_MAXD, mdl_pkg::MAXD_RST);
		wr(mdl_pkg::A_TGT, 32'h0);
		tk(3);
		wr(mdl_pkg::A_ACC, 32'h000a_000a);
		wr(mdl_pkg::A_TGT, 32'h12c);
		chg(11'h000);
		chk("accel 1", q[10:0], 11'h00a);
		chg(11'h00a);
		chk("accel 2", q[10:0], 11'h014);
		wr(mdl_pkg::A_TGT, 32'hffff_fed4);
		chg(11'h014);
		chk("accel rev", q[10:0], 11'h7f6);
		wr(mdl_pkg::A_ACC, 32'h0);
		wr(mdl_pkg::A_TGT, 32'h64);
		tk(3);
		wr(mdl_pkg::A_BRK, 32'h2);
		wr(mdl_pkg::A_TGT, 32'hffff_ff9c);
		chg(11'h064);
		chk("brake hold", q[10:0], 11'h000);
		tk(1);
		duty("brake hold 2", 11'h000);
		tk(5);
		duty("after brake", 11'h79c);
		wr(mdl_pkg::A_BRK, 32'h0);
		$display("limits done");
		wr(mdl_pkg::A_TGT, 32'h12c);
		load <= 8'hc8;
		wr(mdl_pkg::A_MAXC, 32'h0064_0064);
		tk(6);
		rd(mdl_pkg::A_STATE);
		chk("cur limited", 32'($signed(q[10:0]) < 300), 32'h1);
		chk("over flag", q[19], 1'b1);
		load <= 8'h0;
		tk(4);
		duty("cur free", 11'h12c);
		wr(mdl_pkg::A_ECFG, 32'h21);
		wr(mdl_pkg::A_IEN, 32'h1f);
		err_in <= 4'h1;
		tk(2);
		duty("err on", 11'h000);
		chk("irq", irq, 1'b1);
		err_in <= 4'h0;
		tk(3);
		duty("err gone", 11'h12c);
		rd(mdl_pkg::A_STAT);
		chk("stat", q, 32'h1);
		wr(mdl_pkg::A_CLR, 32'h1);
		rd(mdl_pkg::A_STAT);
		chk("cleared", q, 32'h0);
		chk("irq clr", irq, 1'b0);
		wr(mdl_pkg::A_IEN, 32'h0);
		err_in <= 4'h2;
		tk(3);
		duty("err dis", 11'h12c);
		rd(mdl_pkg::A_STAT);
		chk("occurred", q, 32'h2);
		chk("irq mask", irq, 1'b0);
		err_in <= 4'h0;
		wr(mdl_pkg::A_CLR, 32'h1f);
		err_in <= 4'h4;
		tk(2);
		err_in <= 4'h0;
		tk(3);
		rd(mdl_pkg::A_STATE);
		chk("latched", q[17:0], {1'b1, 17'h0});
		rd(mdl_pkg::A_STAT);
		chk("latch stat", q, 32'h14);
		wr(mdl_pkg::A_TGT, 32'h12c);
		tk(3);
		duty("restart", 11'h12c);
		$display("current and errors done");
		test_done();
	end
	initial begin
		repeat (100000) @(posedge pclk);
		fail_count++;
		test_done();
	end
endmodule
